//--- hdl/msg_tx_arbiter.sv
// Outgoing message arbiter: one pending flag for each of the three kinds it sends
`timescale 1ns/1ns
`default_nettype none
module msg_tx_arbiter
   import pcie_role_pkg::*;
(
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_req_ack,
   input  wire logic         i_req_turnoff,
   input  wire logic         i_req_pme,
   input  wire logic [15:0]  i_rid,
   input  wire logic         i_ready,
   output logic              o_valid,
   output msg_code_type      o_code,
   output logic [15:0]       o_rid,
   output logic              o_ack_sent
);

   typedef struct packed {
      logic          pend_ack;
      logic          pend_to;
      logic          pend_pme;
      logic          valid;
      msg_code_type  code;
      logic [15:0]   rid;
   } arb_state_type;

   arb_state_type st_ff;
   arb_state_type nxt_st;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_st          = st_ff;
      // Requests never lost while an earlier message is stalled
      nxt_st.pend_ack = st_ff.pend_ack | i_req_ack;
      nxt_st.pend_to  = st_ff.pend_to | i_req_turnoff;
      nxt_st.pend_pme = st_ff.pend_pme | i_req_pme;
      if (!st_ff.valid || i_ready) begin
         nxt_st.valid = 1'b0;
         nxt_st.rid   = i_rid;
         // Ack first: power may be cut right after it
         if (nxt_st.pend_ack) begin
            nxt_st.valid    = 1'b1;
            nxt_st.code     = MSG_PME_TO_ACK;
            nxt_st.pend_ack = 1'b0;
         end else if (nxt_st.pend_to) begin
            nxt_st.valid   = 1'b1;
            nxt_st.code    = MSG_PME_TURN_OFF;
            nxt_st.pend_to = 1'b0;
         end else if (nxt_st.pend_pme) begin
            nxt_st.valid    = 1'b1;
            nxt_st.code     = MSG_PM_PME;
            nxt_st.pend_pme = 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_valid    = st_ff.valid;
   assign o_code     = st_ff.code;
   assign o_rid      = st_ff.rid;
   assign o_ack_sent = st_ff.valid && i_ready && (st_ff.code == MSG_PME_TO_ACK);

   ////////////////////////////////////////////////////////////////////////
   tx_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (o_valid && !i_ready) |=> (o_valid && $stable(o_code) && $stable(o_rid)))
      else $error("Outgoing message changed while stalled");

endmodule
`default_nettype wire

//--- hdl/pcie_role_cfg_sideband.sv
// Role-specific configuration sideband between link core and user logic
//
// Behaviour
// - Endpoint bus number output is 8 bits and zero after reset.
// - As endpoint, bus and device numbers reload on every received Type 0 configuration request.
// - Endpoint device number output is 5 bits and zero after reset.
// - Function number output is always zero.
// - Received turn-off message drives notice low, then turn-off-ok is watched.
// - Once turn-off-ok is low, a turn-off acknowledge goes upstream.
// - One-cycle low wake pulse makes the endpoint send a PM_PME message.
// - Root uses downstream bus and device only in messages it builds itself.
// - Write under override sets each write-one-to-clear bit written as one.
// - Under override zeros leave those bits, other bit kinds never change.
// - Without override a one clears such a bit; only events set it.
// - Root pulses message-received whenever a message arrives from the link.
// - Root shows the message requester identity alongside message-received.
// - Root flags correctable, nonfatal and fatal error messages with message-received.
// - Low send-turn-off makes the root send a turn-off message.
// - Root flags the acknowledge and, in the same cycle, reports L2/L3 ready on link state.
// - Link state codes: L0, L1, L2/L3 ready, PM_PME, L0s, transitions.
// - Root raises turn-off-ack flag with message-received on acknowledge arrival.
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module pcie_role_cfg_sideband
   import pcie_role_pkg::*;
(
   input  wire logic               I_CLK,
   input  wire logic               I_RST_N,
   // Register bus
   input  wire logic               I_PSEL,
   input  wire logic               I_PENABLE,
   input  wire logic               I_PWRITE,
   input  wire logic [APB_AW-1:0]  I_PADDR,
   input  wire logic [31:0]        I_PWDATA,
   output logic [31:0]             O_PRDATA,
   output logic                    O_PREADY,
   output logic                    O_PSLVERR,
   // Link core side
   input  wire logic               I_RX_CFG0_VALID,
   input  wire logic [7:0]         I_RX_CFG0_BUS,
   input  wire logic [4:0]         I_RX_CFG0_DEV,
   input  wire logic               I_RX_MSG_VALID,
   input  wire msg_code_type       I_RX_MSG_CODE,
   input  wire logic [15:0]        I_RX_MSG_RID,
   input  wire logic [2:0]         I_LINK_STATE,
   output logic                    O_TX_MSG_VALID,
   output msg_code_type            O_TX_MSG_CODE,
   output logic [15:0]             O_TX_MSG_RID,
   input  wire logic               I_TX_MSG_READY,
   // Endpoint user side
   output logic [7:0]              O_BUS_NUM,
   output logic [4:0]              O_DEV_NUM,
   output logic [2:0]              O_FUNC_NUM,
   output logic                    O_TURNOFF_NOTICE_L,
   input  wire logic               I_TURNOFF_OK_L,
   input  wire logic               I_WAKE_REQUEST_L,
   // Root user side
   input  wire logic [7:0]         I_DOWNSTREAM_BUS_NUM,
   input  wire logic [4:0]         I_DOWNSTREAM_DEV_NUM,
   input  wire logic               I_CONFIG_WR_L,
   input  wire logic               I_W1C_OVERRIDE_L,
   input  wire logic [31:0]        I_CONFIG_WRITE_DATA,
   output logic                    O_MSG_RECEIVED,
   output logic [15:0]             O_MSG_RID,
   output logic                    O_GOT_ERR_COR,
   output logic                    O_GOT_ERR_NONFATAL,
   output logic                    O_GOT_ERR_FATAL,
   output logic                    O_GOT_TURNOFF_ACK,
   input  wire logic               I_SEND_TURNOFF_L,
   output logic [2:0]              O_LINK_STATE
);

   typedef struct packed {
      logic               role_root;
      logic [7:0]         bus;
      logic [4:0]         dev;
      turnoff_state_type  to_st;
      logic               turnoff_sent;
      logic               l3;
      logic [2:0]         link;
      logic               msg_rx;
      logic [15:0]        msg_rid;
      logic               got_cor;
      logic               got_nf;
      logic               got_fatal;
      logic               got_ack;
      logic [31:0]        cfgstat;
      logic [31:0]        prdata;
   } main_state_type;

   main_state_type st_ff;
   main_state_type nxt_st;

   logic        req_ack;
   logic        req_turnoff;
   logic        req_pme;
   logic        ack_sent;
   logic [15:0] tx_rid;
   logic [31:0] cs_set;
   logic [1:0]  apb_sel;

   // Register select: 0 none, 1 control, 2 status, 3 configuration status
   function automatic logic [1:0] reg_select(input logic [APB_AW-1:0] addr);
      if (addr == OFS_CTRL) begin
         return 2'h1;
      end else if (addr == OFS_STATUS) begin
         return 2'h2;
      end else if (addr == OFS_CFGSTAT) begin
         return 2'h3;
      end else begin
         return 2'h0;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   assign apb_sel = reg_select(I_PADDR);

   assign tx_rid = st_ff.role_root ? {I_DOWNSTREAM_BUS_NUM, I_DOWNSTREAM_DEV_NUM, FUNC_NUM}
                                   : {st_ff.bus, st_ff.dev, FUNC_NUM};

   always_comb begin
      nxt_st      = st_ff;
      req_ack     = 1'b0;
      req_turnoff = 1'b0;
      req_pme     = 1'b0;
      cs_set      = '0;

      // APB: writes land in the access phase, read data is staged in setup
      if (I_PSEL && I_PENABLE && I_PWRITE && (apb_sel == 2'h1)) begin
         nxt_st.role_root = I_PWDATA[CTRL_ROOT_BIT];
      end
      if (I_PSEL && !I_PENABLE) begin
         nxt_st.prdata = '0;
         if (apb_sel == 2'h1) begin
            nxt_st.prdata[CTRL_ROOT_BIT] = st_ff.role_root;
         end else if (apb_sel == 2'h2) begin
            nxt_st.prdata[ST_BUS_LSB +: 8]  = st_ff.bus;
            nxt_st.prdata[ST_DEV_LSB +: 5]  = st_ff.dev;
            nxt_st.prdata[ST_TO_LSB +: 2]   = st_ff.to_st;
            nxt_st.prdata[ST_L3_BIT]        = st_ff.l3;
            nxt_st.prdata[ST_LINK_LSB +: 3] = O_LINK_STATE;
         end else if (apb_sel == 2'h3) begin
            nxt_st.prdata = st_ff.cfgstat;
         end
      end

      nxt_st.link = I_LINK_STATE;

      // Identity refresh on Type 0 request
      if (!st_ff.role_root && I_RX_CFG0_VALID) begin
         nxt_st.bus = I_RX_CFG0_BUS;
         nxt_st.dev = I_RX_CFG0_DEV;
      end

      case (st_ff.to_st)
         TO_IDLE: begin
            if (!st_ff.role_root && I_RX_MSG_VALID && (I_RX_MSG_CODE == MSG_PME_TURN_OFF)) begin
               nxt_st.to_st = TO_NOTICE;
            end
         end
         TO_NOTICE: begin
            if (!I_TURNOFF_OK_L) begin
               req_ack      = 1'b1;
               nxt_st.to_st = TO_ACK;
            end
         end
         TO_ACK: begin
            if (ack_sent) begin
               nxt_st.to_st = TO_IDLE;
            end
         end
         default: begin
            nxt_st.to_st = TO_IDLE;
         end
      endcase

      // Wake pulse queues a PM_PME message
      req_pme = !st_ff.role_root && !I_WAKE_REQUEST_L;

      // One turn-off message per assertion of the request
      if (!I_SEND_TURNOFF_L) begin
         req_turnoff         = st_ff.role_root && !st_ff.turnoff_sent;
         nxt_st.turnoff_sent = 1'b1;
      end else begin
         nxt_st.turnoff_sent = 1'b0;
      end

      // Received message indications are one-cycle pulses
      nxt_st.msg_rx    = st_ff.role_root && I_RX_MSG_VALID;
      nxt_st.msg_rid   = I_RX_MSG_RID;
      nxt_st.got_cor   = nxt_st.msg_rx && (I_RX_MSG_CODE == MSG_ERR_COR);
      nxt_st.got_nf    = nxt_st.msg_rx && (I_RX_MSG_CODE == MSG_ERR_NONFATAL);
      nxt_st.got_fatal = nxt_st.msg_rx && (I_RX_MSG_CODE == MSG_ERR_FATAL);
      nxt_st.got_ack   = nxt_st.msg_rx && (I_RX_MSG_CODE == MSG_PME_TO_ACK);
      // L3 entry sticks: the link is about to lose power
      if (nxt_st.got_ack) begin
         nxt_st.l3 = 1'b1;
      end

      cs_set[CS_COR_BIT]   = nxt_st.got_cor;
      cs_set[CS_NF_BIT]    = nxt_st.got_nf;
      cs_set[CS_FATAL_BIT] = nxt_st.got_fatal;
      cs_set[CS_TOACK_BIT] = nxt_st.got_ack;

      if (!I_CONFIG_WR_L) begin
         if (!I_W1C_OVERRIDE_L) begin
            nxt_st.cfgstat = st_ff.cfgstat | (I_CONFIG_WRITE_DATA & W1C_MASK);
         end else begin
            nxt_st.cfgstat = (I_CONFIG_WRITE_DATA & ~W1C_MASK)
                           | (st_ff.cfgstat & W1C_MASK & ~I_CONFIG_WRITE_DATA);
         end
      end
      // Event set wins over a same-cycle clear
      nxt_st.cfgstat = nxt_st.cfgstat | cs_set;
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         st_ff         <= '0;
         st_ff.bus     <= BUS_NUM_RST;
         st_ff.dev     <= DEV_NUM_RST;
         st_ff.to_st   <= TO_IDLE;
         st_ff.cfgstat <= CFGSTAT_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   msg_tx_arbiter u_tx (
      .i_clk         (I_CLK),
      .i_rst_n       (I_RST_N),
      .i_req_ack     (req_ack),
      .i_req_turnoff (req_turnoff),
      .i_req_pme     (req_pme),
      .i_rid         (tx_rid),
      .i_ready       (I_TX_MSG_READY),
      .o_valid       (O_TX_MSG_VALID),
      .o_code        (O_TX_MSG_CODE),
      .o_rid         (O_TX_MSG_RID),
      .o_ack_sent    (ack_sent)
   );

   ////////////////////////////////////////////////////////////////////////
   // Zero-wait slave; unmapped addresses answer with an error
   assign O_PRDATA           = st_ff.prdata;
   assign O_PREADY           = 1'b1;
   assign O_PSLVERR          = I_PSEL && I_PENABLE && (apb_sel == 2'h0);

   assign O_BUS_NUM          = st_ff.bus;
   assign O_DEV_NUM          = st_ff.dev;
   assign O_FUNC_NUM         = FUNC_NUM;
   assign O_TURNOFF_NOTICE_L = (st_ff.to_st != TO_NOTICE);
   assign O_MSG_RECEIVED     = st_ff.msg_rx;
   assign O_MSG_RID          = st_ff.msg_rid;
   assign O_GOT_ERR_COR      = st_ff.got_cor;
   assign O_GOT_ERR_NONFATAL = st_ff.got_nf;
   assign O_GOT_ERR_FATAL    = st_ff.got_fatal;
   assign O_GOT_TURNOFF_ACK  = st_ff.got_ack;
   // Link state code, forced to L2/L3 ready after the acknowledge
   assign O_LINK_STATE       = st_ff.l3 ? LS_L23_READY : st_ff.link;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);

   sequence tx_ack_s;
      O_TX_MSG_VALID && (O_TX_MSG_CODE == MSG_PME_TO_ACK);
   endsequence

   sequence turnoff_rx_s;
      !st_ff.role_root && I_RX_MSG_VALID && (I_RX_MSG_CODE == MSG_PME_TURN_OFF)
         && (st_ff.to_st == TO_IDLE);
   endsequence

   id_reset_a: assert property (!$past(I_RST_N) |-> (O_BUS_NUM == BUS_NUM_RST)
      && (O_DEV_NUM == DEV_NUM_RST) && !O_MSG_RECEIVED && O_TURNOFF_NOTICE_L)
      else $error("Outputs not at reset values after reset");
   id_update_a: assert property ((I_RX_CFG0_VALID && !st_ff.role_root) |=>
      (O_BUS_NUM == $past(I_RX_CFG0_BUS)) && (O_DEV_NUM == $past(I_RX_CFG0_DEV)))
      else $error("Bus or device number not refreshed");
   func_zero_a: assert property (O_FUNC_NUM == 3'h0)
      else $error("Function number not zero");
   notice_low_a: assert property (turnoff_rx_s |=> !O_TURNOFF_NOTICE_L [*1])
      else $error("Turn-off notice not driven");
   ack_send_a: assert property ((!O_TURNOFF_NOTICE_L && !I_TURNOFF_OK_L && I_TX_MSG_READY)
      |-> ##[1:4] tx_ack_s)
      else $error("Turn-off acknowledge not sent");
   wake_send_a: assert property ((!st_ff.role_root && !I_WAKE_REQUEST_L && I_TX_MSG_READY
      && !O_TX_MSG_VALID) |-> ##[1:6] (O_TX_MSG_VALID && (O_TX_MSG_CODE == MSG_PM_PME)))
      else $error("PM_PME message not sent");
   root_rid_a: assert property (($rose(O_TX_MSG_VALID) && st_ff.role_root) |->
      (O_TX_MSG_RID == $past({I_DOWNSTREAM_BUS_NUM, I_DOWNSTREAM_DEV_NUM, FUNC_NUM})))
      else $error("Root message identity wrong");
   // Override sets ones, plain bits hold
   w1c_set_a: assert property ((!I_CONFIG_WR_L && !I_W1C_OVERRIDE_L) |=>
      ((st_ff.cfgstat & $past(I_CONFIG_WRITE_DATA) & W1C_MASK)
         == ($past(I_CONFIG_WRITE_DATA) & W1C_MASK))
      && ((st_ff.cfgstat & ~W1C_MASK) == ($past(st_ff.cfgstat) & ~W1C_MASK)))
      else $error("Override write did not set bits");
   w1c_clear_a: assert property ((!I_CONFIG_WR_L && I_W1C_OVERRIDE_L && !I_RX_MSG_VALID)
      |=> ((st_ff.cfgstat & $past(I_CONFIG_WRITE_DATA) & W1C_MASK) == 32'h0000_0000))
      else $error("Write of one did not clear bit");
   err_flag_a: assert property ((st_ff.role_root && I_RX_MSG_VALID
      && (I_RX_MSG_CODE == MSG_ERR_FATAL)) |=> O_MSG_RECEIVED && O_GOT_ERR_FATAL
      && (O_MSG_RID == $past(I_RX_MSG_RID)))
      else $error("Fatal error message not flagged");
   flag_pair_a: assert property ((O_GOT_ERR_COR || O_GOT_ERR_NONFATAL || O_GOT_ERR_FATAL
      || O_GOT_TURNOFF_ACK) |-> O_MSG_RECEIVED)
      else $error("Message flag without message-received");
   turnoff_tx_a: assert property (($fell(I_SEND_TURNOFF_L) && st_ff.role_root
      && I_TX_MSG_READY && !O_TX_MSG_VALID) |->
      ##[1:6] (O_TX_MSG_VALID && (O_TX_MSG_CODE == MSG_PME_TURN_OFF)))
      else $error("Turn-off message not sent");
   l3_report_a: assert property ((st_ff.role_root && I_RX_MSG_VALID
      && (I_RX_MSG_CODE == MSG_PME_TO_ACK)) |=> O_GOT_TURNOFF_ACK
      ##1 (O_LINK_STATE == LS_L23_READY))
      else $error("Acknowledge or L3 ready not reported");

endmodule
`default_nettype wire

//--- include/pcie_role_pkg.sv
// Shared constants and types for the role-specific configuration sideband
package pcie_role_pkg;

   // Link power state codes reported to the user
   localparam logic [2:0]  LS_L0        = 3'h0;
   localparam logic [2:0]  LS_L1        = 3'h1;
   localparam logic [2:0]  LS_L23_READY = 3'h2;
   localparam logic [2:0]  LS_PM_PME    = 3'h3;
   localparam logic [2:0]  LS_L0S       = 3'h4;
   localparam logic [2:0]  LS_TO_L1     = 3'h5;
   localparam logic [2:0]  LS_TO_L23    = 3'h6;

   // Message kinds seen on the link side, both directions
   typedef enum logic [2:0] {
      MSG_NONE,
      MSG_ERR_COR,
      MSG_ERR_NONFATAL,
      MSG_ERR_FATAL,
      MSG_PME_TO_ACK,
      MSG_PME_TURN_OFF,
      MSG_PM_PME,
      MSG_OTHER
   } msg_code_type;

   typedef enum logic [1:0] {
      TO_IDLE,
      TO_NOTICE,
      TO_ACK
   } turnoff_state_type;

   // Identity reset values
   localparam logic [7:0]  BUS_NUM_RST  = 8'h00;
   localparam logic [4:0]  DEV_NUM_RST  = 5'h00;
   localparam logic [2:0]  FUNC_NUM     = 3'h0;

   // Register map, byte addresses
   localparam int          APB_AW       = 8;
   localparam logic [7:0]  OFS_CTRL     = 8'h00;
   localparam logic [7:0]  OFS_STATUS   = 8'h04;
   localparam logic [7:0]  OFS_CFGSTAT  = 8'h08;

   // Control and status field positions
   localparam int          CTRL_ROOT_BIT = 0;
   localparam int          ST_BUS_LSB    = 0;
   localparam int          ST_DEV_LSB    = 8;
   localparam int          ST_TO_LSB     = 13;
   localparam int          ST_L3_BIT     = 15;
   localparam int          ST_LINK_LSB   = 16;

   // Configuration status word: upper half write-one-to-clear
   localparam logic [31:0] W1C_MASK      = 32'hffff_0000;
   localparam logic [31:0] CFGSTAT_RST   = 32'h0000_0000;
   localparam int          CS_COR_BIT    = 16;
   localparam int          CS_NF_BIT     = 17;
   localparam int          CS_FATAL_BIT  = 18;
   localparam int          CS_TOACK_BIT  = 19;

endpackage

//--- test/pcie_role_cfg_sideband_tb.sv
// Self-checking bench for the role-specific configuration sideband
`timescale 1ns/1ns
`default_nettype none
module pcie_role_cfg_sideband_tb import pcie_role_pkg::*;;
   logic         I_CLK, I_RST_N, I_PSEL, I_PENABLE, I_PWRITE, O_PREADY, O_PSLVERR;
   logic [7:0]   I_PADDR, I_RX_CFG0_BUS, O_BUS_NUM, I_DOWNSTREAM_BUS_NUM;
   logic [31:0]  I_PWDATA, O_PRDATA, I_CONFIG_WRITE_DATA, rd;
   logic [4:0]   I_RX_CFG0_DEV, O_DEV_NUM, I_DOWNSTREAM_DEV_NUM;
   logic [2:0]   I_LINK_STATE, O_FUNC_NUM, O_LINK_STATE;
   logic [15:0]  I_RX_MSG_RID, O_TX_MSG_RID, O_MSG_RID;
   logic         I_RX_CFG0_VALID, I_RX_MSG_VALID, O_TX_MSG_VALID, I_TX_MSG_READY;
   logic         O_TURNOFF_NOTICE_L, I_TURNOFF_OK_L, I_WAKE_REQUEST_L, I_CONFIG_WR_L;
   logic         I_W1C_OVERRIDE_L, O_MSG_RECEIVED, O_GOT_ERR_COR, O_GOT_ERR_NONFATAL;
   logic         O_GOT_ERR_FATAL, O_GOT_TURNOFF_ACK, I_SEND_TURNOFF_L, stall, er;
   msg_code_type I_RX_MSG_CODE, O_TX_MSG_CODE;
   int           num_errors, num_checks;
   typedef struct packed {msg_code_type code; logic [15:0] rid; logic [3:0] flg;} row_type;
   row_type rows [4] = '{'{MSG_ERR_COR, 16'h1234, 4'h8}, '{MSG_ERR_NONFATAL, 16'habcd, 4'h4},
                         '{MSG_ERR_FATAL, 16'h0001, 4'h2}, '{MSG_OTHER, 16'hfffe, 4'h0}};

   pcie_role_cfg_sideband DUT (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_PSEL(I_PSEL),
      .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
      .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
      .I_RX_CFG0_VALID(I_RX_CFG0_VALID), .I_RX_CFG0_BUS(I_RX_CFG0_BUS),
      .I_RX_CFG0_DEV(I_RX_CFG0_DEV), .I_RX_MSG_VALID(I_RX_MSG_VALID),
      .I_RX_MSG_CODE(I_RX_MSG_CODE), .I_RX_MSG_RID(I_RX_MSG_RID),
      .I_LINK_STATE(I_LINK_STATE), .O_TX_MSG_VALID(O_TX_MSG_VALID),
      .O_TX_MSG_CODE(O_TX_MSG_CODE), .O_TX_MSG_RID(O_TX_MSG_RID),
      .I_TX_MSG_READY(I_TX_MSG_READY), .O_BUS_NUM(O_BUS_NUM), .O_DEV_NUM(O_DEV_NUM),
      .O_FUNC_NUM(O_FUNC_NUM), .O_TURNOFF_NOTICE_L(O_TURNOFF_NOTICE_L),
      .I_TURNOFF_OK_L(I_TURNOFF_OK_L), .I_WAKE_REQUEST_L(I_WAKE_REQUEST_L),
      .I_DOWNSTREAM_BUS_NUM(I_DOWNSTREAM_BUS_NUM), .I_DOWNSTREAM_DEV_NUM(I_DOWNSTREAM_DEV_NUM),
      .I_CONFIG_WR_L(I_CONFIG_WR_L), .I_W1C_OVERRIDE_L(I_W1C_OVERRIDE_L),
      .I_CONFIG_WRITE_DATA(I_CONFIG_WRITE_DATA), .O_MSG_RECEIVED(O_MSG_RECEIVED),
      .O_MSG_RID(O_MSG_RID), .O_GOT_ERR_COR(O_GOT_ERR_COR),
      .O_GOT_ERR_NONFATAL(O_GOT_ERR_NONFATAL), .O_GOT_ERR_FATAL(O_GOT_ERR_FATAL),
      .O_GOT_TURNOFF_ACK(O_GOT_TURNOFF_ACK), .I_SEND_TURNOFF_L(I_SEND_TURNOFF_L),
      .O_LINK_STATE(O_LINK_STATE));

   user_app_model user_app (.i_clk(I_CLK), .i_rst_n(I_RST_N), .i_notice_l(O_TURNOFF_NOTICE_L),
      .i_stall(stall), .o_turnoff_ok_l(I_TURNOFF_OK_L), .o_tx_ready(I_TX_MSG_READY));

   always #5 I_CLK = ~I_CLK;

   ////////////////////////////////////////////////////////////////////////
   // Wide enough to carry the error bit beside a full data word
   task chk(input logic [32:0] got, input logic [32:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
         num_errors++;
      end
   endtask

   task wrap_up();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge I_CLK);
      I_PSEL    <= 1'b1;
      I_PENABLE <= 1'b0;
      I_PWRITE  <= w;
      I_PADDR   <= a;
      I_PWDATA  <= d;
      @(posedge I_CLK);
      I_PENABLE <= 1'b1;
      // No wait-state limit of its own: only the watchdog ends a hung access
      do begin
         @(posedge I_CLK);
      end while (O_PREADY !== 1'b1);
      rd = O_PRDATA;
      er = O_PSLVERR;
      I_PSEL    <= 1'b0;
      I_PENABLE <= 1'b0;
   endtask

   task rx(input msg_code_type c, input logic [15:0] r);
      @(posedge I_CLK);
      I_RX_MSG_VALID <= 1'b1;
      I_RX_MSG_CODE  <= c;
      I_RX_MSG_RID   <= r;
      @(posedge I_CLK);
      I_RX_MSG_VALID <= 1'b0;
      @(negedge I_CLK);
   endtask

   task cw(input logic ovr_l, input logic [31:0] d);
      @(posedge I_CLK);
      I_CONFIG_WR_L       <= 1'b0;
      I_W1C_OVERRIDE_L    <= ovr_l;
      I_CONFIG_WRITE_DATA <= d;
      @(posedge I_CLK);
      I_CONFIG_WR_L    <= 1'b1;
      I_W1C_OVERRIDE_L <= 1'b1;
   endtask

   task wait_tx(input msg_code_type c, input logic [15:0] r);
      int n;
      n = 0;
      do begin
         @(negedge I_CLK);
         n++;
      end while (!(O_TX_MSG_VALID === 1'b1 && I_TX_MSG_READY === 1'b1) && n < 50);
      chk(O_TX_MSG_VALID, 1'b1);
      chk(O_TX_MSG_CODE, c);
      chk(O_TX_MSG_RID, r);
      @(posedge I_CLK);
   endtask

   task idle_chk();
      @(negedge I_CLK);
      chk(O_BUS_NUM, 8'h00);
      chk(O_DEV_NUM, 5'h00);
      chk(O_FUNC_NUM, 3'h0);
      chk(O_TURNOFF_NOTICE_L, 1'b1);
      chk(O_LINK_STATE, LS_L0);
      chk({O_MSG_RECEIVED, O_TX_MSG_VALID}, 2'h0);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      I_CLK = 0; I_RST_N = 0; I_PSEL = 0; I_PENABLE = 0; I_PWRITE = 0; I_PADDR = 0;
      I_PWDATA = 0; I_RX_CFG0_VALID = 0; I_RX_CFG0_BUS = 0; I_RX_CFG0_DEV = 0;
      I_RX_MSG_VALID = 0; I_RX_MSG_CODE = MSG_NONE; I_RX_MSG_RID = 0; I_WAKE_REQUEST_L = 1;
      I_DOWNSTREAM_BUS_NUM = 8'h21; I_DOWNSTREAM_DEV_NUM = 5'h07; I_CONFIG_WR_L = 1;
      I_W1C_OVERRIDE_L = 1; I_CONFIG_WRITE_DATA = 0; I_SEND_TURNOFF_L = 1; stall = 0;
      I_LINK_STATE = LS_L0;
      num_errors = 0; num_checks = 0;
      repeat (6) @(posedge I_CLK);
      I_RST_N <= 1'b1;
      idle_chk();
      @(posedge I_CLK);
      I_RX_CFG0_VALID <= 1'b1;
      I_RX_CFG0_BUS   <= 8'h5a;
      I_RX_CFG0_DEV   <= 5'h13;
      @(posedge I_CLK);
      I_RX_CFG0_VALID <= 1'b0;
      @(negedge I_CLK);
      chk({O_BUS_NUM, O_DEV_NUM, O_FUNC_NUM}, 16'h5a98);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk({er, rd}, 33'h0_0000_135a);
      // Far side stalls so the wake message must hold
      @(posedge I_CLK);
      stall            <= 1'b1;
      I_WAKE_REQUEST_L <= 1'b0;
      @(posedge I_CLK);
      I_WAKE_REQUEST_L <= 1'b1;
      repeat (3) @(negedge I_CLK);
      chk({O_TX_MSG_VALID, O_TX_MSG_CODE}, {1'b1, MSG_PM_PME});
      @(posedge I_CLK);
      stall <= 1'b0;
      wait_tx(MSG_PM_PME, 16'h5a98);
      rx(MSG_PME_TURN_OFF, 16'h0100);
      chk(O_TURNOFF_NOTICE_L, 1'b0);
      wait_tx(MSG_PME_TO_ACK, 16'h5a98);
      apb(1'b1, OFS_CTRL, 32'h1);
      apb(1'b0, OFS_CTRL, 32'h0);
      chk({er, rd}, 33'h1);
      apb(1'b0, 8'h40, 32'h0);
      chk({er, rd}, 33'h1_0000_0000);
      for (int i = 0; i < 4; i++) begin
         rx(rows[i].code, rows[i].rid);
         chk(O_MSG_RECEIVED, 1'b1);
         chk(O_MSG_RID, rows[i].rid);
         chk({O_GOT_ERR_COR, O_GOT_ERR_NONFATAL, O_GOT_ERR_FATAL, O_GOT_TURNOFF_ACK},
             rows[i].flg);
      end
      @(negedge I_CLK);
      chk(O_MSG_RECEIVED, 1'b0);
      cw(1'b0, 32'h00f0_ffff);
      apb(1'b0, OFS_CFGSTAT, 32'h0);
      chk(rd, 32'h00f7_0000);
      cw(1'b1, 32'h0001_1234);
      apb(1'b0, OFS_CFGSTAT, 32'h0);
      chk(rd, 32'h00f6_1234);
      @(posedge I_CLK);
      I_SEND_TURNOFF_L <= 1'b0;
      wait_tx(MSG_PME_TURN_OFF, 16'h2138);
      I_SEND_TURNOFF_L <= 1'b1;
      rx(MSG_PME_TO_ACK, 16'h5a98);
      chk({O_MSG_RECEIVED, O_GOT_TURNOFF_ACK}, 2'h3);
      chk(O_LINK_STATE, LS_L23_READY);
      // Second reset must clear sticky state and learned numbers
      @(posedge I_CLK);
      I_RST_N <= 1'b0;
      repeat (6) @(posedge I_CLK);
      I_RST_N <= 1'b1;
      idle_chk();
      // Wake with the far side ready: identity is back at zero
      @(posedge I_CLK);
      I_WAKE_REQUEST_L <= 1'b0;
      @(posedge I_CLK);
      I_WAKE_REQUEST_L <= 1'b1;
      wait_tx(MSG_PM_PME, 16'h0000);
      I_LINK_STATE <= LS_TO_L1;
      repeat (2) @(negedge I_CLK);
      chk(O_LINK_STATE, LS_TO_L1);
      wrap_up();
   end

   // Whole sequence needs well under 1000 cycles
   initial begin
      #100000;
      num_errors++;
      wrap_up();
   end
endmodule
`default_nettype wire

//--- test/user_app_model.sv
// User logic model beside the link core: turn-off consent and TX backpressure
`timescale 1ns/1ns
`default_nettype none
module user_app_model (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_notice_l,
   input  wire logic i_stall,
   output logic      o_turnoff_ok_l,
   output logic      o_tx_ready
);
   logic [1:0] wait_ff;

   ////////////////////////////////////////////////////////////////////////
   assign o_tx_ready = !i_stall;

   // Consent only when safe
   // Consent waits a few cycles so the notice is seen as a level, not a glitch
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || i_notice_l) begin
         wait_ff        <= 2'h0;
         o_turnoff_ok_l <= 1'b1;
      end else if (wait_ff != 2'h3) begin
         wait_ff <= wait_ff + 2'h1;
      end else begin
         o_turnoff_ok_l <= 1'b0;
      end
   end
endmodule
`default_nettype wire
